//--- verilog/sc_etu_pkg.sv
// Shared constants for the smart card convention and ETU control block.
package sc_etu_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int ETU_W = 13;
    localparam logic [15:0] IDX_CLK_SEL = 16'hfe0f;
    localparam logic [15:0] IDX_PARITY = 16'hfe11;
    localparam logic [15:0] IDX_BYTE_CTL = 16'hfe12;
    localparam logic [15:0] IDX_FD = 16'hfe13;
    localparam logic [15:0] IDX_STATUS = 16'hfe1f;
    localparam logic [ADDR_W-1:0] ADDR_CLK_SEL = {IDX_CLK_SEL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PARITY = {IDX_PARITY, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_BYTE_CTL = {IDX_BYTE_CTL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_FD = {IDX_FD, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
    localparam logic [7:0] RST_CLK_SEL = 8'h8c;
    localparam logic [7:0] RST_PARITY = 8'h00;
    localparam logic [7:0] RST_BYTE_CTL = 8'h28;
    localparam logic [7:0] RST_FD = 8'h11;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_T0 = 7;
    localparam int CLK_SEL_MSB = 5;
    localparam int BIT_PAR_OFF = 6;
    localparam int BIT_BRK_OFF = 5;
    localparam int BIT_TS_DET = 6;
    localparam int BIT_CONV = 5;
    localparam int BRK_SEL_MSB = 4;
    localparam int BRK_SEL_LSB = 3;
    localparam int F_MSB = 7;
    localparam int F_LSB = 4;
    localparam int D_MSB = 3;

    // ****************************************************************
    // Character timing in half-ETU steps from the start bit edge, break lengths in half-ETU steps, and the raw indirect TS
    // ****************************************************************
    localparam logic [4:0] HALF_FIRST_SAMPLE = 5'h03;
    localparam logic [4:0] HALF_LAST_SAMPLE = 5'h13;
    localparam logic [4:0] HALF_BREAK = 5'h15;
    localparam logic [4:0] HALF_CARD_BRK = 5'h16;
    localparam logic [2:0] BRK_HALVES_1 = 3'h2;
    localparam logic [2:0] BRK_HALVES_1P5 = 3'h3;
    localparam logic [2:0] BRK_HALVES_2 = 3'h4;
    localparam logic [7:0] TS_RAW_INDIRECT = 8'h03;

    // ****************************************************************
    // Conversion factors
    // ****************************************************************
    localparam logic [3:0] F_CODE_EXC = 4'h2;
    localparam logic [3:0] D_CODE_EXC = 4'h4;
    localparam logic [ETU_W-1:0] ETU_COUNT_EXC = 13'h08a;

    function automatic logic [11:0] fi_of(input logic [3:0] code);
        logic [11:0] v;
        v = 12'h174;
        case (code)
            4'h2: v = 12'h22e;
            4'h3: v = 12'h2e8;
            4'h4: v = 12'h45c;
            4'h5: v = 12'h5d0;
            4'h6, 4'h7: v = 12'h744;
            4'h8, 4'h9: v = 12'h200;
            4'ha: v = 12'h300;
            4'hb: v = 12'h400;
            4'hc: v = 12'h600;
            4'hd, 4'he, 4'hf: v = 12'h800;
            default: v = 12'h174;
        endcase
        return v;
    endfunction

    function automatic logic [5:0] di_of(input logic [3:0] code);
        logic [5:0] v;
        v = 6'h10;
        case (code)
            4'h0, 4'h1: v = 6'h01;
            4'h2: v = 6'h02;
            4'h3: v = 6'h04;
            4'h4: v = 6'h08;
            4'h5: v = 6'h10;
            4'h6, 4'h7: v = 6'h20;
            4'h8: v = 6'h0c;
            4'h9: v = 6'h14;
            default: v = 6'h10;
        endcase
        return v;
    endfunction
endpackage

//--- verilog/sc_clk_divider.sv
// Intermediate clock enable and card clock generator.
`timescale 1ns/1ps
module sc_clk_divider (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Control
    input wire logic [5:0] i_div_sel,
    // Outputs
    output logic o_tick,
    output logic o_card_clk
);
    logic [5:0] cnt_q;
    logic [6:0] ratio_q;
    logic card_clk_q;
    wire logic [6:0] ratio_new;
    wire logic wrap;

    assign ratio_new = (i_div_sel == 6'h00) ? 7'h02 : {1'b0, i_div_sel} + 7'h01;
    assign wrap = ({1'b0, cnt_q} + 7'h01) >= ratio_q;
    assign o_tick = wrap;
    assign o_card_clk = card_clk_q;

    // A new ratio is taken only at a wrap, so no period is ever cut short.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= 6'h00;
            ratio_q <= 7'h0d;
        end else if (wrap) begin
            cnt_q <= 6'h00;
            ratio_q <= ratio_new;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            card_clk_q <= 1'b0;
        end else if (wrap) begin
            card_clk_q <= ~card_clk_q;
        end
    end
endmodule

//--- verilog/sc_etu_divider.sv
// ETU divider: maps F and D codes to a count and emits half-ETU ticks.
`timescale 1ns/1ps
module sc_etu_divider #(
    parameter int ETU_W = sc_etu_pkg::ETU_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Timing
    input wire logic i_tick,
    input wire logic i_restart,
    input wire logic [3:0] i_f_code,
    input wire logic [3:0] i_d_code,
    // Outputs
    output logic o_half_tick,
    output logic [ETU_W-1:0] o_etu_count
);
    logic [ETU_W-1:0] cnt_q;
    wire logic [11:0] fi;
    wire logic [5:0] di;
    wire logic [13:0] num;
    wire logic [ETU_W-1:0] etu_round;
    wire logic [ETU_W-1:0] half_pt;
    wire logic last;

    assign fi = sc_etu_pkg::fi_of(i_f_code);
    assign di = sc_etu_pkg::di_of(i_d_code);
    assign num = {1'b0, fi, 1'b0} + {9'h000, di[5:1]};
    // rounding to nearest keeps a 4096 count and stays within half a count.
    assign etu_round = ETU_W'(num / {8'h00, di});
    assign o_etu_count = (i_f_code == sc_etu_pkg::F_CODE_EXC && i_d_code == sc_etu_pkg::D_CODE_EXC)
        ? sc_etu_pkg::ETU_COUNT_EXC : etu_round;
    assign half_pt = o_etu_count >> 1;
    assign last = (cnt_q + 1'b1) >= o_etu_count;
    assign o_half_tick = i_tick && !i_restart && (last || (cnt_q + 1'b1) == half_pt);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= '0;
        end else if (i_restart) begin
            cnt_q <= '0;
        end else if (i_tick) begin
            cnt_q <= last ? '0 : cnt_q + 1'b1;
        end
    end
endmodule

//--- verilog/smartcard_etu_convention_ctrl.sv
// Smart card receive convention, break and ETU rate control with Avalon-MM registers.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps

// Behaviour
// - With TS detect set, next received character is TS and fixes the convention.
// - Without TS detect, the convention bit stays as is, direct after reset.
// - TS gets the same parity check and break as selected by control bits.
// - Hardware clears TS detect once TS has been received.
// - TS is decoded by its convention before being handed on.
// - TS sets the convention bit for direct, clears it for indirect; software may write.
// - Break length code 00 is 1 ETU, 01 is 1.5, 10 is 2, 11 reserved.
// - Upper nibble selects Fi; reset code 0001 gives 372.
// - Lower nibble selects Di; reset code 0001 gives 1.
// - F code table 372,372,558,744,1116,1488,1860,1860,512,512,768,1024,1536,2048x3.
// - D code table 1,1,2,4,8,16,32,32,12,20, then 16 for the rest.
// - Card clock is the intermediate clock divided by two.
// - ETU is the intermediate clock divided by twice Fi over Di.
// - Fi over Di ratios up to 2048 are supported.
// - Divider loads the tabulated count, e.g. 744 and 138.
// - Inexact counts stay within half a count of the target ratio except the 138 loaded for 139.5; rounding gives 23 for 23.25, about 1.1 percent off.
// - One F and D setting serves whichever interface is selected.
// - Intermediate clock is system clock over select plus one; zero acts as one.
// - Parity break starts at 10.5 ETU; card break is sampled at 11 ETU.
// - Parity check, when on, demands even ones including the parity bit.
module smartcard_etu_convention_ctrl #(
    parameter int ADDR_W = sc_etu_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Card line
    input wire logic i_card_io_in,
    output logic o_card_io_out,
    output logic o_card_io_oe,
    output logic o_card_clk,
    // Received characters
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_rx_parity_err
);
    typedef enum logic [0:0] {RX_IDLE, RX_FRAME} rx_state_t;

    // ****************************************************************
    // Registers and decode
    // ****************************************************************
    logic wait_q;
    logic [31:0] rdata_q;
    logic [7:0] clk_sel_q;
    logic par_off_q;
    logic brk_off_q;
    logic ts_detect_q;
    logic conv_q;
    logic [1:0] brk_sel_q;
    logic [7:0] fd_q;
    wire logic req;
    wire logic wr_ok;
    wire logic hit_clk;
    wire logic hit_par;
    wire logic hit_byte;
    wire logic hit_fd;
    wire logic hit_stat;
    wire logic [7:0] wd;
    wire logic [7:0] rd_byte;
    wire logic [7:0] status;
    wire logic ts_done;
    wire logic ts_direct;

    assign req = i_avs_read | i_avs_write;
    assign wr_ok = i_avs_write & ~wait_q & i_avs_byteenable[0];
    assign hit_clk = i_avs_address == sc_etu_pkg::ADDR_CLK_SEL;
    assign hit_par = i_avs_address == sc_etu_pkg::ADDR_PARITY;
    assign hit_byte = i_avs_address == sc_etu_pkg::ADDR_BYTE_CTL;
    assign hit_fd = i_avs_address == sc_etu_pkg::ADDR_FD;
    assign hit_stat = i_avs_address == sc_etu_pkg::ADDR_STATUS;
    assign wd = i_avs_writedata[7:0];

    assign rd_byte = hit_clk ? clk_sel_q :
        hit_par ? {1'b0, par_off_q, brk_off_q, 5'h00} :
        hit_byte ? {1'b0, ts_detect_q, conv_q, brk_sel_q, 3'h0} :
        hit_fd ? fd_q :
        hit_stat ? status : 8'h00;

    assign o_avs_waitrequest = wait_q;
    assign o_avs_readdata = rdata_q;

    // The slave answers one cycle after the request is first seen.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~(req & wait_q);
            if (i_avs_read & wait_q) begin
                rdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            clk_sel_q <= sc_etu_pkg::RST_CLK_SEL;
            par_off_q <= sc_etu_pkg::RST_PARITY[sc_etu_pkg::BIT_PAR_OFF];
            brk_off_q <= sc_etu_pkg::RST_PARITY[sc_etu_pkg::BIT_BRK_OFF];
            fd_q <= sc_etu_pkg::RST_FD;
        end else if (wr_ok) begin
            if (hit_clk) begin
                clk_sel_q <= {wd[sc_etu_pkg::BIT_T0], 1'b0, wd[sc_etu_pkg::CLK_SEL_MSB:0]};
            end
            if (hit_par) begin
                par_off_q <= wd[sc_etu_pkg::BIT_PAR_OFF];
                brk_off_q <= wd[sc_etu_pkg::BIT_BRK_OFF];
            end
            if (hit_fd) begin
                fd_q <= wd;
            end
        end
    end

    // A software write of TS detect beats the clear at TS end, so a re-arm is kept.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ts_detect_q <= sc_etu_pkg::RST_BYTE_CTL[sc_etu_pkg::BIT_TS_DET];
            conv_q <= sc_etu_pkg::RST_BYTE_CTL[sc_etu_pkg::BIT_CONV];
            brk_sel_q <= sc_etu_pkg::RST_BYTE_CTL[sc_etu_pkg::BRK_SEL_MSB:sc_etu_pkg::BRK_SEL_LSB];
        end else begin
            if (wr_ok && hit_byte) begin
                ts_detect_q <= wd[sc_etu_pkg::BIT_TS_DET];
                brk_sel_q <= wd[sc_etu_pkg::BRK_SEL_MSB:sc_etu_pkg::BRK_SEL_LSB];
            end else if (ts_done) begin
                ts_detect_q <= 1'b0;
            end
            // hardware update wins over a write.
            if (ts_done) begin
                conv_q <= ts_direct;
            end else if (wr_ok && hit_byte) begin
                conv_q <= wd[sc_etu_pkg::BIT_CONV];
            end
        end
    end

    // ****************************************************************
    // Clock and ETU dividers
    // ****************************************************************
    wire logic icc_tick;
    wire logic half_tick;
    wire logic start_edge;
    wire logic [sc_etu_pkg::ETU_W-1:0] etu_count;

    // one F and D setting drives the shared divider.
    sc_clk_divider u_clk_div (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_div_sel(clk_sel_q[sc_etu_pkg::CLK_SEL_MSB:0]),
        .o_tick(icc_tick),
        .o_card_clk(o_card_clk)
    );

    sc_etu_divider u_etu_div (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(icc_tick),
        .i_restart(start_edge),
        .i_f_code(fd_q[sc_etu_pkg::F_MSB:sc_etu_pkg::F_LSB]),
        .i_d_code(fd_q[sc_etu_pkg::D_MSB:0]),
        .o_half_tick(half_tick),
        .o_etu_count(etu_count)
    );

    // ****************************************************************
    // Character receiver
    // ****************************************************************
    rx_state_t state_q;
    logic io_prev_q;
    logic [4:0] half_q;
    logic [8:0] shift_q;
    logic char_done_q;
    logic ts_frame_q;
    logic pend_brk_q;
    logic [2:0] brk_cnt_q;
    logic oe_q;
    logic card_brk_q;
    logic [7:0] rx_data_q;
    logic rx_valid_q;
    logic par_err_q;
    wire logic [4:0] half_next;
    wire logic sample_pt;
    wire logic conv_eff;
    wire logic par_err_w;
    wire logic [7:0] raw;
    wire logic [7:0] decoded;
    wire logic [2:0] brk_len;
    wire logic brk_start;
    wire logic [2:0] brk_cnt_d;
    wire logic frame_end;

    assign start_edge = (state_q == RX_IDLE) && io_prev_q && !i_card_io_in && !oe_q;
    assign half_next = half_q + 5'h01;
    assign sample_pt = half_tick && half_next[0] && half_next >= sc_etu_pkg::HALF_FIRST_SAMPLE
        && half_next <= sc_etu_pkg::HALF_LAST_SAMPLE;
    assign raw = shift_q[7:0];
    // a TS frame decides its own convention.
    assign ts_direct = raw != sc_etu_pkg::TS_RAW_INDIRECT;
    assign conv_eff = ts_frame_q ? ts_direct : conv_q;
    // even parity, inverted levels in indirect.
    assign par_err_w = !par_off_q && (conv_eff ? ^shift_q : ~^shift_q);
    assign decoded = conv_eff ? raw : ~{<<{raw}};
    assign ts_done = char_done_q && ts_frame_q;
    assign brk_len = (brk_sel_q == 2'h1) ? sc_etu_pkg::BRK_HALVES_1P5 :
        (brk_sel_q == 2'h2) ? sc_etu_pkg::BRK_HALVES_2 : sc_etu_pkg::BRK_HALVES_1;
    assign brk_start = half_tick && (state_q == RX_FRAME) && pend_brk_q
        && half_next == sc_etu_pkg::HALF_BREAK;
    assign brk_cnt_d = brk_start ? brk_len :
        (half_tick && brk_cnt_q != 3'h0) ? brk_cnt_q - 3'h1 : brk_cnt_q;
    assign frame_end = (state_q == RX_FRAME) && half_q >= sc_etu_pkg::HALF_CARD_BRK
        && brk_cnt_q == 3'h0;
    assign status = {5'h00, state_q == RX_FRAME, card_brk_q, par_err_q};

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= RX_IDLE;
            half_q <= 5'h00;
        end else begin
            unique case (state_q)
                RX_IDLE: begin
                    if (start_edge) begin
                        state_q <= RX_FRAME;
                        half_q <= 5'h00;
                    end
                end
                RX_FRAME: begin
                    if (frame_end) begin
                        state_q <= RX_IDLE;
                    end else if (half_tick && half_q < sc_etu_pkg::HALF_CARD_BRK) begin
                        half_q <= half_next;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            io_prev_q <= 1'b1;
            shift_q <= 9'h000;
            char_done_q <= 1'b0;
            ts_frame_q <= 1'b0;
        end else begin
            io_prev_q <= i_card_io_in;
            char_done_q <= sample_pt && half_next == sc_etu_pkg::HALF_LAST_SAMPLE;
            if (start_edge) begin
                ts_frame_q <= ts_detect_q;
            end
            if (sample_pt && state_q == RX_FRAME) begin
                shift_q <= {i_card_io_in, shift_q[8:1]};
            end
        end
    end

    // Only T=0 with checking and sending enabled may answer a bad parity with a break.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pend_brk_q <= 1'b0;
            brk_cnt_q <= 3'h0;
            oe_q <= 1'b0;
            card_brk_q <= 1'b0;
        end else begin
            brk_cnt_q <= brk_cnt_d;
            oe_q <= brk_cnt_d != 3'h0;
            if (start_edge) begin
                pend_brk_q <= 1'b0;
                card_brk_q <= 1'b0;
            end else if (char_done_q) begin
                pend_brk_q <= par_err_w && clk_sel_q[sc_etu_pkg::BIT_T0] && !brk_off_q;
            end else if (half_tick && half_next == sc_etu_pkg::HALF_CARD_BRK
                    && state_q == RX_FRAME && half_q < sc_etu_pkg::HALF_CARD_BRK) begin
                // card break sampled at 11 ETU.
                card_brk_q <= !i_card_io_in && !oe_q;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
            par_err_q <= 1'b0;
        end else begin
            rx_valid_q <= char_done_q;
            if (char_done_q) begin
                rx_data_q <= decoded;
                par_err_q <= par_err_w;
            end
        end
    end

    // The card line is open drain: only a low is ever driven.
    assign o_card_io_out = 1'b0;
    assign o_card_io_oe = oe_q;
    assign o_rx_data = rx_data_q;
    assign o_rx_valid = rx_valid_q;
    assign o_rx_parity_err = par_err_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_brk_on;
        brk_start ##1 o_card_io_oe;
    endsequence

    property p_ts_clear;
        @(posedge i_clk) disable iff (i_sys_rst)
        ts_done && !(wr_ok && hit_byte) |=> !ts_detect_q;
    endproperty
    a_ts_clear: assert property (p_ts_clear) else $error("TS detect not cleared");

    property p_conv_ind;
        @(posedge i_clk) disable iff (i_sys_rst)
        ts_done && raw == sc_etu_pkg::TS_RAW_INDIRECT |=> !conv_q;
    endproperty
    a_conv_ind: assert property (p_conv_ind) else $error("indirect TS not recorded");

    property p_decode;
        @(posedge i_clk) disable iff (i_sys_rst)
        char_done_q && !conv_eff |=> o_rx_valid && o_rx_data == ~{<<{$past(raw)}};
    endproperty
    a_decode: assert property (p_decode) else $error("indirect decode wrong");

    property p_brk_1etu;
        @(posedge i_clk) disable iff (i_sys_rst)
        brk_start && brk_sel_q == 2'h0 |-> s_brk_on ##0 (brk_cnt_q == 3'h2);
    endproperty
    a_brk_1etu: assert property (p_brk_1etu) else $error("break length wrong");

    property p_no_brk_par_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        char_done_q && par_off_q |=> !pend_brk_q;
    endproperty
    a_no_brk_par_off: assert property (p_no_brk_par_off) else $error("break with parity off");

    property p_etu_744;
        @(posedge i_clk) disable iff (i_sys_rst)
        fd_q == 8'h11 |-> etu_count == 13'h2e8;
    endproperty
    a_etu_744: assert property (p_etu_744) else $error("default ETU count wrong");

    property p_etu_138;
        @(posedge i_clk) disable iff (i_sys_rst)
        fd_q == 8'h24 |-> etu_count == 13'h08a;
    endproperty
    a_etu_138: assert property (p_etu_138) else $error("exception ETU count wrong");

    property p_etu_max;
        @(posedge i_clk) disable iff (i_sys_rst)
        fd_q == 8'hd1 |-> etu_count == 13'h1000;
    endproperty
    a_etu_max: assert property (p_etu_max) else $error("max ETU count wrong");

    property p_bus_ack;
        @(posedge i_clk) disable iff (i_sys_rst)
        req && wait_q |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("bus answer timing wrong");

    property p_brk_at_half;
        @(posedge i_clk) disable iff (i_sys_rst)
        $rose(o_card_io_oe) |-> half_q == sc_etu_pkg::HALF_BREAK;
    endproperty
    a_brk_at_half: assert property (p_brk_at_half) else $error("break not at 10.5 ETU");
endmodule

//--- verif/sc_card_model.sv
// Behavioural smart card that sends one character on the open-drain I/O line.
`timescale 1ns/1ps
module sc_card_model (
    // Clock
    input wire logic i_clk,
    // Request
    input wire logic i_send,
    input wire logic [7:0] i_data,
    input wire logic i_bad_parity,
    input wire logic [15:0] i_etu,
    // Line
    output logic o_io,
    output logic o_busy
);
    logic [9:0] frame;
    int k;
    initial begin
        o_io = 1'b1;
        o_busy = 1'b0;
    end
    // The line is pulled up, so it idles high between frames and during the break window.
    always @(posedge i_clk) begin
        if (i_send && !o_busy) begin
            o_busy <= 1'b1;
            frame = {(^i_data) ^ i_bad_parity, i_data, 1'b0};
            for (k = 0; k < 10; k++) begin
                o_io <= frame[k];
                repeat (i_etu) @(posedge i_clk);
            end
            o_io <= 1'b1;
            repeat (3 * i_etu) @(posedge i_clk);
            o_busy <= 1'b0;
        end
    end
endmodule

//--- verif/smartcard_etu_convention_ctrl_test.sv
// Self-checking bench for the smart card convention and ETU control block.
`timescale 1ns/1ps
module smartcard_etu_convention_ctrl_test;
    logic i_clk = 0, i_sys_rst = 1, rd = 0, wr = 0, send = 0, badp = 0;
    logic [17:0] adr = '0;
    logic [31:0] wdat = '0, rdata;
    logic [7:0] cdat = '0, rx, got, r;
    logic wreq, oe, valid, perr, card_io, busy, got_perr;
    int errors = 0, n_compared = 0, cyc = 0, oe_cnt = 0;
    always #20 i_clk = ~i_clk;
    smartcard_etu_convention_ctrl uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_card_io_in(card_io & ~oe), .o_card_io_out(), .o_card_io_oe(oe), .o_card_clk(),
        .o_rx_data(rx), .o_rx_valid(valid), .o_rx_parity_err(perr));
    // ETU of 32 intermediate ticks at divide by two is 64 system clocks.
    sc_card_model card (.i_clk(i_clk), .i_send(send), .i_data(cdat), .i_bad_parity(badp),
        .i_etu(16'h0040), .o_io(card_io), .o_busy(busy));
    always @(posedge i_clk) begin
        cyc++;
        if (oe === 1'b1) oe_cnt++;
        if (valid === 1'b1) begin
            got = rx;
            got_perr = perr;
        end
        if (cyc == 30000) begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ****************************************************************
    // Bus and card helpers
    // ****************************************************************
    task automatic bus(input logic we, input logic [17:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge i_clk);
        rd <= ~we;
        wr <= we;
        adr <= a;
        wdat <= {24'h0, wd};
        // Waitrequest and read data are taken at the rising edge that sees waitrequest low.
        do begin
            @(posedge i_clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        if (n >= 40) errors++;
        r = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [17:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, {8'h00, r}, {8'h00, e});
    endtask
    task automatic send_char(input logic [7:0] d, input logic bad);
        int n;
        n = 0;
        oe_cnt = 0;
        @(posedge i_clk);
        cdat <= d;
        badp <= bad;
        send <= 1'b1;
        @(posedge i_clk);
        send <= 1'b0;
        do begin
            @(negedge i_clk);
            n++;
        end while (busy === 1'b1 && n < 2000);
        if (n >= 2000) errors++;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        rchk("fd", sc_etu_pkg::ADDR_FD, 8'h11);
        rchk("byte_ctl", sc_etu_pkg::ADDR_BYTE_CTL, 8'h28);
        rchk("unmapped", 18'h00000, 8'h00);
        bus(1'b1, sc_etu_pkg::ADDR_FD, 8'h96);
        rchk("fd new", sc_etu_pkg::ADDR_FD, 8'h96);
    endtask
    task automatic t_ts_indirect();
        bus(1'b1, sc_etu_pkg::ADDR_CLK_SEL, 8'h01);
        bus(1'b1, sc_etu_pkg::ADDR_BYTE_CTL, 8'h68);
        // Indirect line levels are inverted, so the raw parity must be odd.
        send_char(8'h03, 1'b1);
        chk("ts data", {8'h00, got}, 16'h003f);
        chk("ts parity", {15'h0, got_perr}, 16'h0000);
        chk("ts no break", 16'(oe_cnt), 16'h0000);
        rchk("ts ctl", sc_etu_pkg::ADDR_BYTE_CTL, 8'h08);
    endtask
    task automatic t_parity_break();
        bus(1'b1, sc_etu_pkg::ADDR_CLK_SEL, 8'h81);
        bus(1'b1, sc_etu_pkg::ADDR_BYTE_CTL, 8'h30);
        send_char(8'ha5, 1'b1);
        chk("rx data", {8'h00, got}, 16'h00a5);
        chk("parity err", {15'h0, got_perr}, 16'h0001);
        chk("break len", 16'(oe_cnt), 16'd128);
        rchk("ctl kept", sc_etu_pkg::ADDR_BYTE_CTL, 8'h30);
        rchk("status", sc_etu_pkg::ADDR_STATUS, 8'h01);
        bus(1'b1, sc_etu_pkg::ADDR_BYTE_CTL, 8'h20);
        send_char(8'h5a, 1'b1);
        chk("break 1 etu", 16'(oe_cnt), 16'd64);
        bus(1'b1, sc_etu_pkg::ADDR_BYTE_CTL, 8'hff);
        rchk("reserved", sc_etu_pkg::ADDR_BYTE_CTL, 8'h78);
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_regs();
        t_ts_indirect();
        t_parity_break();
        summarize();
    end
endmodule
